// ==== inc/fivm_pkg.sv ====
/*
 * Constants and carrier types for the framer interrupt vector mask block.
 * Assumes a 16-bit host port with register offsets as decoded addresses.
 */
package fivm_pkg;

	// =========================================================
	// Register offsets
	localparam logic [11:0] FIVM_OFF_GCTL1 = 12'h901;
	localparam logic [11:0] FIVM_OFF_MASK1 = 12'h902;
	localparam logic [11:0] FIVM_OFF_VSTAT = 12'h910;

	// =========================================================
	// Field layout: framer f owns bits 4f+3 down to 4f.
	localparam int FIVM_NFRM        = 4;
	localparam int FIVM_SRC_PER_FRM = 4;
	localparam int FIVM_POS_HDLC    = 3;
	localparam int FIVM_POS_ELASTIC = 2;
	localparam int FIVM_POS_RXLINE  = 1;
	localparam int FIVM_POS_SYNC    = 0;

	// Global control 1 fields.
	localparam int FIVM_G1_CONT  = 0;
	localparam int FIVM_G1_BUFEN = 5;
	localparam int FIVM_G1_AIE   = 8;
	localparam int FIVM_G1_AFULL = 9;

	// =========================================================
	// Reset values and write masks
	localparam logic [15:0] FIVM_GCTL1_RST  = 16'h0000;
	localparam logic [15:0] FIVM_MASK1_RST  = 16'h0000;
	localparam logic [15:0] FIVM_VSTAT_RST  = 16'h0000;
	localparam logic [15:0] FIVM_GCTL1_WMSK = 16'hF9FF;

	// =========================================================
	// Analyser buffer
	localparam int          FIVM_ABUF_AW   = 5;
	localparam logic [4:0]  FIVM_ABUF_LAST = 5'h1F;
	localparam logic [4:0]  FIVM_ABUF_FRST = 5'h00;

	typedef enum logic [2:0] {
		FIVM_ST_IDLE = 3'b001,
		FIVM_ST_FILL = 3'b010,
		FIVM_ST_DONE = 3'b100
	} fivm_astate_t;

	// =========================================================
	// Carriers
	typedef struct packed {
		logic        sel;
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [15:0] wdata;
	} fivm_host_t;

	typedef struct packed {
		logic       we;
		logic [4:0] addr;
	} fivm_abuf_t;

endpackage

// ==== design/fivm_analyser.sv ====
/*
 * Fill sequencer for the backplane analyser buffer.
 * Assumes sample_i marks one capture slot per cycle, synchronous to clk.
 */
`timescale 1ns/1ps
module fivm_analyser
(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               ce,
	input  wire logic               enable_i,
	input  wire logic               continuous_i,
	input  wire logic               sample_i,
	input  wire logic               clear_full_i,
	output fivm_pkg::fivm_abuf_t    abuf_r,
	output logic                    full_r
);

	fivm_pkg::fivm_astate_t state_r;
	fivm_pkg::fivm_astate_t state_nxt;
	fivm_pkg::fivm_abuf_t   abuf_nxt;
	logic                   lock_r;
	logic                   lock_nxt;
	logic                   full_nxt;

	// =========================================================
	// Sequencer
	wire logic take_w = (state_r == fivm_pkg::FIVM_ST_FILL) && sample_i;
	wire logic last_w = take_w && (abuf_r.addr == fivm_pkg::FIVM_ABUF_LAST);

	always_comb
	begin
		state_nxt     = state_r;
		abuf_nxt.we   = take_w;
		abuf_nxt.addr = abuf_r.addr;
		unique case (state_r)
			fivm_pkg::FIVM_ST_IDLE:
			begin
				abuf_nxt.addr = fivm_pkg::FIVM_ABUF_FRST;
				if (enable_i)
					state_nxt = fivm_pkg::FIVM_ST_FILL;
			end
			fivm_pkg::FIVM_ST_FILL:
			begin
				if (!enable_i)
					state_nxt = fivm_pkg::FIVM_ST_IDLE;
				else if (last_w && !continuous_i)
					state_nxt = fivm_pkg::FIVM_ST_DONE;
				if (take_w)
					abuf_nxt.addr = last_w ? fivm_pkg::FIVM_ABUF_FRST
						: abuf_r.addr + 5'h01;
			end
			fivm_pkg::FIVM_ST_DONE:
			begin
				if (!enable_i)
					state_nxt = fivm_pkg::FIVM_ST_IDLE;
				else if (continuous_i)
					state_nxt = fivm_pkg::FIVM_ST_FILL;
			end
			default:
				state_nxt = fivm_pkg::FIVM_ST_IDLE;
		endcase
	end

	// =========================================================
	// Full flag
	// Buffer full raises the flag.
	// A flag raised in single mode stays until reset.
	assign lock_nxt = lock_r || (last_w && !continuous_i);
	assign full_nxt = last_w || (full_r && (lock_r || !clear_full_i
		|| !continuous_i));

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= fivm_pkg::FIVM_ST_IDLE;
			abuf_r  <= '0;
			full_r  <= 1'b0;
			lock_r  <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			abuf_r  <= abuf_nxt;
			full_r  <= full_nxt;
			lock_r  <= lock_nxt;
		end
	end

	// =========================================================
	// Checks
	a_cont_wraps: assert property (@(posedge clk) disable iff (!rstn)
		ce && last_w && continuous_i && enable_i |=>
		abuf_r.addr == fivm_pkg::FIVM_ABUF_FRST
		&& state_r == fivm_pkg::FIVM_ST_FILL)
		else $error("continuous fill did not wrap");

	a_single_stops: assert property (@(posedge clk) disable iff (!rstn)
		ce && state_r == fivm_pkg::FIVM_ST_DONE |=> !abuf_r.we)
		else $error("buffer written after single fill");

	a_full_sticky: assert property (@(posedge clk) disable iff (!rstn)
		lock_r |=> full_r && lock_r)
		else $error("single mode full flag was cleared");

	a_cont_clear: assert property (@(posedge clk) disable iff (!rstn)
		ce && full_r && clear_full_i && continuous_i && !lock_r && !last_w
		|=> !full_r)
		else $error("continuous full flag not cleared");

endmodule

// ==== design/fivm_top.sv ====
/*
 * Interrupt vector mask for framers 3 to 0, vector status and the
 * analyser control register, on the 16-bit host port.
 * Assumes host strobes and sources are synchronous to clk.
 */
`timescale 1ns/1ps
module fivm_top
(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               ce,
	input  fivm_pkg::fivm_host_t    host_i,
	output logic [15:0]             rdata_r,
	input  wire logic [15:0]        src_i,
	input  wire logic               sample_i,
	output fivm_pkg::fivm_abuf_t    abuf_r,
	output logic                    irq_r
);

	logic [15:0] gctl1_r;
	logic [15:0] mask1_r;
	logic [15:0] vstat_r;
	logic [15:0] vstat_nxt;
	logic [15:0] rdata_nxt;
	logic        irq_nxt;
	logic        afull_w;
	logic        rst_seen_r;

	function automatic logic hit(input fivm_pkg::fivm_host_t h,
		input logic [11:0] off);
		hit = h.sel && (h.addr == off);
	endfunction

	// =========================================================
	// Host decode
	wire logic wr_g1_w = host_i.wr && hit(host_i, fivm_pkg::FIVM_OFF_GCTL1);
	wire logic wr_m1_w = host_i.wr && hit(host_i, fivm_pkg::FIVM_OFF_MASK1);
	wire logic rd_g1_w = host_i.rd && hit(host_i, fivm_pkg::FIVM_OFF_GCTL1);
	wire logic rd_m1_w = host_i.rd && hit(host_i, fivm_pkg::FIVM_OFF_MASK1);
	wire logic rd_vs_w = host_i.rd && hit(host_i, fivm_pkg::FIVM_OFF_VSTAT);

	wire logic [15:0] g1_view_w = (gctl1_r & fivm_pkg::FIVM_GCTL1_WMSK)
		| (16'(afull_w) << fivm_pkg::FIVM_G1_AFULL);

	assign rdata_nxt = rd_g1_w ? g1_view_w
		: rd_m1_w ? mask1_r
		: rd_vs_w ? vstat_r
		: 16'h0000;

	// =========================================================
	// Vector status gating
	genvar f;
	genvar s;
	generate
		for (f = 0; f < fivm_pkg::FIVM_NFRM; f++)
		begin : g_frm
			for (s = 0; s < fivm_pkg::FIVM_SRC_PER_FRM; s++)
			begin : g_src
				localparam int B = f * fivm_pkg::FIVM_SRC_PER_FRM + s;
				assign vstat_nxt[B] = src_i[B] && !mask1_r[B];
			end
		end
	endgenerate

	// Any status bit or enabled full flag.
	assign irq_nxt = (|vstat_nxt)
		|| (gctl1_r[fivm_pkg::FIVM_G1_AIE] && afull_w);

	// =========================================================
	// Registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gctl1_r <= fivm_pkg::FIVM_GCTL1_RST;
			mask1_r <= fivm_pkg::FIVM_MASK1_RST;
			vstat_r <= fivm_pkg::FIVM_VSTAT_RST;
			rdata_r <= 16'h0000;
			irq_r   <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_g1_w)
				gctl1_r <= host_i.wdata & fivm_pkg::FIVM_GCTL1_WMSK;
			// Mask written as a whole word.
			if (wr_m1_w)
				mask1_r <= host_i.wdata;
			vstat_r <= vstat_nxt;
			rdata_r <= rdata_nxt;
			irq_r   <= irq_nxt;
		end
	end

	// =========================================================
	// Analyser
	// Continuous select steers the sequencer.
	fivm_analyser u_analyser
	(
		.clk          (clk),
		.rstn         (rstn),
		.ce           (ce),
		.enable_i     (gctl1_r[fivm_pkg::FIVM_G1_BUFEN]),
		.continuous_i (gctl1_r[fivm_pkg::FIVM_G1_CONT]),
		.sample_i     (sample_i),
		.clear_full_i (rd_g1_w),
		.abuf_r       (abuf_r),
		.full_r       (afull_w)
	);

	// =========================================================
	// Checks
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_seen_r <= 1'b0;
		else
			rst_seen_r <= 1'b1;
	end

	a_masked_zero: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> (vstat_r & $past(mask1_r)) == 16'h0000)
		else $error("masked status bit active");

	a_unmasked_follow: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> (vstat_r & ~$past(mask1_r))
		== ($past(src_i) & ~$past(mask1_r)))
		else $error("unmasked status bit does not follow source");

	a_mask_pos: assert property (@(posedge clk) disable iff (!rstn)
		ce && wr_m1_w ##1 ce && !wr_m1_w ##1 ce && rd_m1_w |=>
		rdata_r[15:13] == $past(host_i.wdata[15:13], 3))
		else $error("framer three mask bits misplaced");

	a_vstat_read: assert property (@(posedge clk) disable iff (!rstn)
		ce && rd_vs_w |=> rdata_r == $past(vstat_r))
		else $error("status read wrong");

	a_mask_reset: assert property (@(posedge clk) disable iff (!rstn)
		!rst_seen_r |-> mask1_r == 16'h0000)
		else $error("mask not zero after reset");

	a_irq_any: assert property (@(posedge clk) disable iff (!rstn)
		ce |=> irq_r == ((|$past(src_i & ~mask1_r))
		|| $past(gctl1_r[fivm_pkg::FIVM_G1_AIE] && afull_w)))
		else $error("interrupt output does not match status");

endmodule

// ==== sim/testbench.sv ====
/*
 * Self-checking testbench for the framer interrupt vector mask block.
 * Assumes fivm_pkg and fivm_top are compiled before this file.
 */
`timescale 1ns/1ps
module testbench;
	logic                 clk;
	logic                 rstn;
	logic                 ce;
	fivm_pkg::fivm_host_t host_i;
	logic [15:0]          rdata_r;
	logic [15:0]          src_i;
	logic                 sample_i;
	fivm_pkg::fivm_abuf_t abuf_r;
	logic                 irq_r;
	int                   n_errors = 0;
	int                   cmp_count = 0;
	int                   cycles = 0;
	logic [15:0]          rd_val;
	logic                 seen;
	logic [4:0]           sa;

	fivm_top fivm_top_i
	(
		.clk      (clk),
		.rstn     (rstn),
		.ce       (ce),
		.host_i   (host_i),
		.rdata_r  (rdata_r),
		.src_i    (src_i),
		.sample_i (sample_i),
		.abuf_r   (abuf_r),
		.irq_r    (irq_r)
	);

	always #50 clk = ~clk;

	// =========================================================
	// Shared tasks
	task stop_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task bus(input int wr, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		host_i <= {1'b1, wr == 0, wr != 0, a, d};
		@(posedge clk);
		host_i <= '0;
		#1 rd_val = rdata_r;
	endtask

	// One capture slot, then watch three cycles for the buffer write.
	task samp;
		seen = 1'b0;
		sa = 5'h00;
		@(posedge clk);
		sample_i <= 1'b1;
		repeat (3)
		begin
			@(posedge clk);
			sample_i <= 1'b0;
			#1;
			if (abuf_r.we === 1'b1)
			begin
				seen = 1'b1;
				sa = abuf_r.addr;
			end
		end
	endtask

	task irq_is(input logic e);
		repeat (3) @(posedge clk);
		#1 chk("irq", {15'h0000, e}, {15'h0000, irq_r});
	endtask

	// =========================================================
	// Scenarios
	task t_reset;
		bus(0, 12'h902, 16'h0000);
		chk("mask1 reset", 16'h0000, rd_val);
		bus(0, 12'h901, 16'h0000);
		chk("gctl1 reset", 16'h0000, rd_val);
		bus(0, 12'h910, 16'h0000);
		chk("status reset", 16'h0000, rd_val);
	endtask

	task t_mask;
		@(posedge clk);
		src_i <= 16'hFFFF;
		for (int b = 0; b < 16; b++)
		begin
			bus(1, 12'h902, 16'h0001 << b);
			bus(0, 12'h902, 16'h0000);
			chk("mask1", 16'h0001 << b, rd_val);
			bus(0, 12'h910, 16'h0000);
			chk("status", ~(16'h0001 << b), rd_val);
		end
		bus(1, 12'hE00, 16'hFFFF);
		bus(0, 12'h902, 16'h0000);
		chk("mask1 kept", 16'h8000, rd_val);
		bus(1, 12'h902, 16'hE000);
		bus(1, 12'h910, 16'h0000);
		bus(0, 12'h910, 16'h0000);
		chk("status ro", 16'h1FFF, rd_val);
		bus(0, 12'h905, 16'h0000);
		chk("unmapped", 16'h0000, rd_val);
	endtask

	task t_irq;
		bus(1, 12'h902, 16'hFFFF);
		irq_is(1'b0);
		bus(1, 12'h902, 16'h7FFF);
		@(posedge clk);
		src_i <= 16'h8000;
		irq_is(1'b1);
		@(posedge clk);
		src_i <= 16'h0000;
		irq_is(1'b0);
	endtask

	task t_cont;
		bus(1, 12'h901, 16'h0021);
		for (int i = 0; i < 32; i++)
		begin
			samp;
			// The write strobe carries the advanced slot pointer.
			chk("buf addr", 16'(i + 1) & 16'h001F, {10'h000, ~seen, sa});
		end
		bus(0, 12'h901, 16'h0000);
		chk("full set", 16'h0221, rd_val);
		bus(0, 12'h901, 16'h0000);
		chk("full clr", 16'h0021, rd_val);
		samp;
		chk("wrap addr", 16'h0001, {10'h000, ~seen, sa});
	endtask

	task t_single;
		int n;
		n = 0;
		bus(1, 12'h901, 16'h0000);
		bus(1, 12'h901, 16'h0120);
		for (int i = 0; i < 33; i++)
		begin
			samp;
			n += seen;
		end
		chk("single writes", 16'h0020, n[15:0]);
		irq_is(1'b1);
		bus(0, 12'h901, 16'h0000);
		bus(0, 12'h901, 16'h0000);
		chk("single full", 16'h0320, rd_val);
		irq_is(1'b1);
	endtask

	// A device reset is the only way to clear a stuck single-mode full flag; clearing AIE only masks its interrupt.
	task t_recover;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		irq_is(1'b0);
		bus(0, 12'h902, 16'h0000);
		chk("mask1 after reset", 16'h0000, rd_val);
		bus(0, 12'h901, 16'h0000);
		chk("gctl1 after reset", 16'h0000, rd_val);
	endtask

	// =========================================================
	// Main sequence and hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			stop_test;
		end
	end

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		ce = 1'b1;
		host_i = '0;
		src_i = 16'h0000;
		sample_i = 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_mask;
		t_irq;
		t_cont;
		t_single;
		t_recover;
		stop_test;
	end
endmodule
